// >>> verilog/twb_consts.svh
// Purpose: timing counts, widths and reset values for the two-wire bus engine
// Assumes: system clock of 40 MHz
// Notes: included by bare name from both ends
`ifndef TWB_CONSTS_SVH
`define TWB_CONSTS_SVH

// system clock rate in MHz
`define SYS_CLK_MHZ 40
// half of one bus clock period in ns (100 kHz bus)
`define SCL_HALF_NS 5000
// half period in system cycles, a least time, so rounded up
`define SCL_HALF_CYC ((`SCL_HALF_NS * `SYS_CLK_MHZ + 999) / 1000)
// data bits in one segment; index of the acknowledge slot
`define DATA_BITS 4'h8
// reset value of bit counters
`define BIT_CNT_RST 4'h0
// slave bit counter preload: two link cycles of data setup before the clock is let go
`define TX_SETUP_CNT 4'hE
// reset value of shift registers
`define SHIFT_RST 8'h00
// own bus address of the device end, arbitrary default
`define OWN_ADDR_DEF 7'h2A

`endif

// >>> verilog/twb_pkg.sv
// Purpose: shared types of the two-wire bus engine
// Assumes: nothing beyond the constants header
// Notes: state codes are one-hot
package twb_pkg;
    // command set of the controlling end
    typedef enum logic [1:0] {
        CMD_START = 2'h0, // (repeated) start, then send data_in as address byte
        CMD_WRITE = 2'h1, // send one data byte
        CMD_READ = 2'h2,  // take one byte, answer with ack_in
        CMD_STOP = 2'h3   // stop and give up the bus
    } cmd_t;

    // controlling end states
    typedef enum logic [10:0] {
        M_IDLE = 11'h001,
        M_HOLD = 11'h002,
        M_RS_LOW = 11'h004,
        M_RS_HIGH = 11'h008,
        M_START = 11'h010,
        M_LO = 11'h020,
        M_HI = 11'h040,
        M_ST_LOW = 11'h080,
        M_ST_HIGH = 11'h100,
        M_ST_END = 11'h200,
        M_LOST = 11'h400
    } mst_state_t;

    // addressed end states
    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_ADDR = 9'h002,
        S_ADDR_ACK = 9'h004,
        S_RX = 9'h008,
        S_RX_ACK = 9'h010,
        S_TX = 9'h020,
        S_TX_WAIT = 9'h040,
        S_TX_ACK = 9'h080,
        S_IGNORE = 9'h100
    } slv_state_t;
endpackage : twb_pkg

// >>> verilog/twb_bus_if.sv
// Purpose: open-drain clock and data wires joining the two ends
// Assumes: pull-ups on both wires
// Notes: each end gives out, oe_n per wire; oe_n low means driving
`timescale 1ns/1ps
`default_nettype none
interface twb_bus_if;
    logic scl;       // resolved clock wire
    logic sda;       // resolved data wire
    logic m_scl_out; // controlling end
    logic m_scl_oe_n;
    logic m_sda_out;
    logic m_sda_oe_n;
    logic s_scl_out; // addressed end
    logic s_scl_oe_n;
    logic s_sda_out;
    logic s_sda_oe_n;

    // wired-and: a released wire floats high through its pull-up
    assign scl = (m_scl_oe_n | m_scl_out) & (s_scl_oe_n | s_scl_out);
    assign sda = (m_sda_oe_n | m_sda_out) & (s_sda_oe_n | s_sda_out);

    modport master (input scl, input sda, output m_scl_out, output m_scl_oe_n,
        output m_sda_out, output m_sda_oe_n);
    modport slave (input scl, input sda, output s_scl_out, output s_scl_oe_n,
        output s_sda_out, output s_sda_oe_n);
endinterface : twb_bus_if
`default_nettype wire

// >>> verilog/twb_master.sv
// Purpose: controlling end: frames, clocks and arbitrates transfers
// Assumes: one command at a time, taken when cmd_ready_out is high
// Notes: bus clock is made from sys_clk_in by a divider
`timescale 1ns/1ps
`default_nettype none
`include "twb_consts.svh"
module twb_master (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire twb_pkg::cmd_t cmd_in,
    input wire logic [7:0] data_in,
    input wire logic ack_in,
    output logic cmd_ready_out,
    output logic done_out,
    output logic [7:0] rd_data_out,
    output logic nack_out,
    output logic arb_lost_out,
    output logic bus_busy_out,
    twb_bus_if.master bus
);
    import twb_pkg::*;

    mst_state_t state; // sequencer
    logic scl_meta, scl_s, scl_p; // clock wire synchroniser and history
    logic sda_meta, sda_s, sda_p; // data wire synchroniser and history
    logic [7:0] tim; // half-period divider
    logic [3:0] bit_cnt; // slot within the segment
    logic [7:0] shreg; // out and in shifter
    logic is_read; // segment direction
    logic ack_bit; // answer to give on a read
    logic scl_drv; // 1 pulls the clock low
    logic sda_drv; // 1 pulls the data low

    wire start_det = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_det = scl_s & scl_p & ~sda_p & sda_s;
    wire tim_done = (tim == 8'(`SCL_HALF_CYC - 1));
    wire hi_wait = (state == M_HI) | (state == M_RS_HIGH) | (state == M_ST_HIGH);
    wire timed = hi_wait | (state == M_RS_LOW) | (state == M_START) | (state == M_LO) |
        (state == M_ST_LOW) | (state == M_ST_END);
    // a high phase counts only once the wire is really high
    wire tim_run = timed & (~hi_wait | scl_s);
    wire ack_slot = (bit_cnt == `DATA_BITS);
    // level wanted on data: the ack slot is released on writes
    wire bit_drive = ack_slot ? (is_read & ack_bit) : (~is_read & ~shreg[7]);
    // only a transmitter that releases a bit can see it pulled low
    wire arb_fail = ~ack_slot & ~is_read & ~bit_drive & ~sda_s;
    wire accept = cmd_valid_in & cmd_ready_out;

    // only a start is taken from idle, and only on a quiet bus
    assign cmd_ready_out = ((state == M_IDLE) & ~bus_busy_out) | (state == M_HOLD);
    // open-drain: never drive high, only pull low
    assign bus.m_scl_out = 1'b0;
    assign bus.m_sda_out = 1'b0;
    assign bus.m_scl_oe_n = ~scl_drv;
    assign bus.m_sda_oe_n = ~sda_drv;

    // pins cross two flops before any logic sees them
    always_ff @(posedge sys_clk_in) begin
        scl_meta <= bus.scl;
        sda_meta <= bus.sda;
        scl_s <= scl_meta;
        sda_s <= sda_meta;
        scl_p <= scl_s;
        sda_p <= sda_s;
    end

    // bus activity monitor, also flags frames of other masters
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            bus_busy_out <= 1'b0;
        end else if (start_det) begin
            bus_busy_out <= 1'b1;
        end else if (stop_det) begin
            bus_busy_out <= 1'b0;
        end
    end

    // half-period divider, restarts on each phase
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !tim_run || tim_done) begin
            tim <= 8'h00;
        end else begin
            tim <= tim + 8'h01;
        end
    end

    // sequencer
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state <= M_IDLE;
            scl_drv <= 1'b0;
            sda_drv <= 1'b0;
            bit_cnt <= `BIT_CNT_RST;
            shreg <= `SHIFT_RST;
            is_read <= 1'b0;
            ack_bit <= 1'b0;
            done_out <= 1'b0;
            rd_data_out <= `SHIFT_RST;
            nack_out <= 1'b0;
            arb_lost_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            arb_lost_out <= 1'b0;
            case (state)
                M_IDLE: begin
                    scl_drv <= 1'b0;
                    sda_drv <= 1'b0;
                    if (accept && cmd_in == CMD_START) begin
                        shreg <= data_in;
                        sda_drv <= 1'b1;
                        state <= M_START;
                    end
                end
                M_HOLD: begin
                    // clock held low between segments
                    bit_cnt <= `BIT_CNT_RST;
                    if (accept) begin
                        case (cmd_in)
                            CMD_START: begin
                                shreg <= data_in;
                                sda_drv <= 1'b0;
                                state <= M_RS_LOW;
                            end
                            CMD_WRITE: begin
                                shreg <= data_in;
                                is_read <= 1'b0;
                                state <= M_LO;
                            end
                            CMD_READ: begin
                                is_read <= 1'b1;
                                ack_bit <= ack_in;
                                sda_drv <= 1'b0;
                                state <= M_LO;
                            end
                            default: begin
                                sda_drv <= 1'b1;
                                state <= M_ST_LOW;
                            end
                        endcase
                    end
                end
                M_RS_LOW: begin
                    if (tim_done) begin
                        scl_drv <= 1'b0;
                        state <= M_RS_HIGH;
                    end
                end
                M_RS_HIGH: begin
                    if (tim_done) begin
                        sda_drv <= 1'b1;
                        state <= M_START;
                    end
                end
                M_START: begin
                    if (tim_done) begin
                        scl_drv <= 1'b1;
                        is_read <= 1'b0;
                        bit_cnt <= `BIT_CNT_RST;
                        state <= M_LO;
                    end
                end
                M_LO: begin
                    // data moves one cycle after the clock fell
                    sda_drv <= bit_drive;
                    if (tim_done) begin
                        scl_drv <= 1'b0;
                        state <= M_HI;
                    end
                end
                M_HI: begin
                    if (scl_s && tim == 8'h00) begin
                        if (arb_fail) begin
                            scl_drv <= 1'b0;
                            sda_drv <= 1'b0;
                            arb_lost_out <= 1'b1;
                            state <= M_LOST;
                        end else if (!ack_slot) begin
                            shreg <= {shreg[6:0], sda_s};
                        end else if (!is_read) begin
                            nack_out <= sda_s;
                        end
                    end else if (tim_done) begin
                        scl_drv <= 1'b1;
                        if (ack_slot) begin
                            // ack level stays until the next command, so data never moves with the clock edge
                            done_out <= 1'b1;
                            if (is_read) begin
                                rd_data_out <= shreg;
                            end
                            state <= M_HOLD;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                            state <= M_LO;
                        end
                    end
                end
                M_ST_LOW: begin
                    if (tim_done) begin
                        scl_drv <= 1'b0;
                        state <= M_ST_HIGH;
                    end
                end
                M_ST_HIGH: begin
                    if (tim_done) begin
                        sda_drv <= 1'b0;
                        state <= M_ST_END;
                    end
                end
                M_ST_END: begin
                    if (tim_done) begin
                        done_out <= 1'b1;
                        state <= M_IDLE;
                    end
                end
                M_LOST: begin
                    // wait for the winner's stop before trying again
                    if (!bus_busy_out) begin
                        state <= M_IDLE;
                    end
                end
                default: begin
                    state <= M_IDLE;
                end
            endcase
        end
    end
endmodule : twb_master
`default_nettype wire

// >>> verilog/twb_slave.sv
// Purpose: addressed end: takes and gives bytes on the two-wire bus
// Assumes: link_clk_in oversamples the bus wires several times per bus bit
// Notes: bus logic runs on link_clk_in, user side on sys_clk_in
`timescale 1ns/1ps
`default_nettype none
`include "twb_consts.svh"
module twb_slave (
    input wire logic sys_clk_in,
    input wire logic link_clk_in,
    input wire logic rst_in,
    input wire logic tx_load_in,
    input wire logic [7:0] tx_data_in,
    output logic tx_ready_out,
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    output logic bus_busy_out,
    twb_bus_if.slave bus
);
    import twb_pkg::*;

    // user side, sys_clk_in
    logic [7:0] tx_hold; // byte offered to the bus side
    logic tx_tgl; // flips on each offer
    logic txa_meta, txa_sync; // consume toggle coming back
    logic rxt_meta, rxt_sync, rxt_seen; // receive toggle coming in
    logic bsy_meta; // busy level crossing

    // bus side, link_clk_in
    slv_state_t state; // sequencer
    logic rst_meta, rst_link; // reset carried into this domain
    logic scl_meta, scl_s, scl_p; // clock wire synchroniser and history
    logic sda_meta, sda_s, sda_p; // data wire synchroniser and history
    logic txt_meta, txt_sync, txt_seen; // offer toggle coming in
    logic [7:0] tx_byte; // byte waiting for the shifter
    logic tx_have; // tx_byte not yet used
    logic txack_tgl; // flips when tx_byte is used
    logic [7:0] rx_byte; // last byte taken in
    logic rx_tgl; // flips on each byte taken in
    logic [3:0] bit_cnt; // slot within the segment
    logic [7:0] shreg; // out and in shifter
    logic rw; // direction of the current message
    logic seen_low; // clock went low since the start
    logic busy; // between start and stop
    logic scl_drv; // 1 stretches the clock
    logic sda_drv; // 1 pulls the data low

    // conditions come only from second-stage samples
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    wire start_det = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_det = scl_s & scl_p & ~sda_p & sda_s & seen_low;
    wire tx_new = txt_sync ^ txt_seen;
    wire seg_end = (bit_cnt == `DATA_BITS);
    wire addr_hit = (shreg[7:1] == `OWN_ADDR_DEF);

    // a new offer is taken only after the previous one was used
    assign tx_ready_out = (tx_tgl == txa_sync);
    // open-drain: never drive high, only pull low
    assign bus.s_scl_out = 1'b0;
    assign bus.s_sda_out = 1'b0;
    assign bus.s_scl_oe_n = ~scl_drv;
    assign bus.s_sda_oe_n = ~sda_drv;

    // user side: offer a byte; holding register is stable until used
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            tx_hold <= `SHIFT_RST;
            tx_tgl <= 1'b0;
        end else if (tx_load_in && tx_ready_out) begin
            tx_hold <= tx_data_in;
            tx_tgl <= ~tx_tgl;
        end
    end

    // user side: crossings in from the bus side
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            txa_meta <= 1'b0;
            txa_sync <= 1'b0;
            rxt_meta <= 1'b0;
            rxt_sync <= 1'b0;
            rxt_seen <= 1'b0;
            bsy_meta <= 1'b0;
            bus_busy_out <= 1'b0;
            rx_valid_out <= 1'b0;
            rx_data_out <= `SHIFT_RST;
        end else begin
            txa_meta <= txack_tgl;
            txa_sync <= txa_meta;
            rxt_meta <= rx_tgl;
            rxt_sync <= rxt_meta;
            rxt_seen <= rxt_sync;
            bsy_meta <= busy;
            bus_busy_out <= bsy_meta;
            // rx_byte stands a whole segment, so it is safe to copy here
            rx_valid_out <= rxt_sync ^ rxt_seen;
            if (rxt_sync ^ rxt_seen) begin
                rx_data_out <= rx_byte;
            end
        end
    end

    // bus side: reset and wires through two flops each
    always_ff @(posedge link_clk_in) begin
        rst_meta <= rst_in;
        rst_link <= rst_meta;
        scl_meta <= bus.scl;
        sda_meta <= bus.sda;
        scl_s <= scl_meta;
        sda_s <= sda_meta;
        scl_p <= scl_s;
        sda_p <= sda_s;
    end

    // bus side: offered byte arrives; a new arrival beats a use
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            txt_meta <= 1'b0;
            txt_sync <= 1'b0;
            txt_seen <= 1'b0;
            tx_byte <= `SHIFT_RST;
            tx_have <= 1'b0;
            txack_tgl <= 1'b0;
        end else begin
            txt_meta <= tx_tgl;
            txt_sync <= txt_meta;
            txt_seen <= txt_sync;
            if (tx_new) begin
                tx_byte <= tx_hold;
                tx_have <= 1'b1;
            end else if (state == S_TX_WAIT && tx_have) begin
                tx_have <= 1'b0;
                txack_tgl <= ~txack_tgl;
            end
        end
    end

    // bus side: busy tracking and the clock-low qualifier for stops
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            busy <= 1'b0;
            seen_low <= 1'b0;
        end else if (start_det) begin
            busy <= 1'b1;
            seen_low <= 1'b0;
        end else if (stop_det) begin
            busy <= 1'b0;
        end else if (!scl_s) begin
            seen_low <= 1'b1;
        end
    end

    // bus side sequencer
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            state <= S_IDLE;
            bit_cnt <= `BIT_CNT_RST;
            shreg <= `SHIFT_RST;
            rw <= 1'b0;
            scl_drv <= 1'b0;
            sda_drv <= 1'b0;
            rx_byte <= `SHIFT_RST;
            rx_tgl <= 1'b0;
        end else if (start_det) begin
            // start and repeated start both reopen address reception
            state <= S_ADDR;
            bit_cnt <= `BIT_CNT_RST;
            scl_drv <= 1'b0;
            sda_drv <= 1'b0;
        end else if (stop_det) begin
            state <= S_IDLE;
            scl_drv <= 1'b0;
            sda_drv <= 1'b0;
        end else begin
            case (state)
                S_ADDR, S_RX: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && seg_end) begin
                        bit_cnt <= `BIT_CNT_RST;
                        if (state == S_RX) begin
                            rx_byte <= shreg;
                            rx_tgl <= ~rx_tgl;
                            sda_drv <= 1'b1;
                            state <= S_RX_ACK;
                        end else if (addr_hit) begin
                            rw <= shreg[0];
                            sda_drv <= 1'b1;
                            state <= S_ADDR_ACK;
                        end else begin
                            state <= S_IGNORE;
                        end
                    end
                end
                S_ADDR_ACK: begin
                    if (scl_fall) begin
                        sda_drv <= 1'b0;
                        // reading master: hold the clock until a byte is ready
                        scl_drv <= rw;
                        state <= rw ? S_TX_WAIT : S_RX;
                    end
                end
                S_RX_ACK: begin
                    if (scl_fall) begin
                        sda_drv <= 1'b0;
                        state <= S_RX;
                    end
                end
                S_TX_WAIT: begin
                    // clock is stretched here, so no edges arrive
                    if (tx_have) begin
                        shreg <= tx_byte;
                        sda_drv <= ~tx_byte[7];
                        // clock stays stretched until the data has settled
                        bit_cnt <= `TX_SETUP_CNT;
                        state <= S_TX;
                    end
                end
                S_TX: begin
                    if (scl_drv) begin
                        // counter wraps to zero as the clock is released
                        bit_cnt <= bit_cnt + 4'h1;
                        scl_drv <= (bit_cnt != 4'hF);
                    end else if (scl_rise) begin
                        if (!sda_drv && !sda_s) begin
                            state <= S_IGNORE;
                        end
                        shreg <= {shreg[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        // release after the eighth bit for the answer
                        sda_drv <= seg_end ? 1'b0 : ~shreg[7];
                        if (seg_end) begin
                            state <= S_TX_ACK;
                        end
                    end
                end
                S_TX_ACK: begin
                    if (scl_rise && sda_s) begin
                        state <= S_IGNORE;
                    end else if (scl_fall) begin
                        scl_drv <= 1'b1;
                        state <= S_TX_WAIT;
                    end
                end
                default: begin
                    // idle or not addressed: wires released
                    scl_drv <= 1'b0;
                    sda_drv <= 1'b0;
                end
            endcase
        end
    end
endmodule : twb_slave
`default_nettype wire

// >>> tb/twb_assertions.sv
// Purpose: wire-level checks between the two bus ends
// Assumes: wires sampled on the system clock
// Notes: frame state is rebuilt here from the wires alone
`timescale 1ns/1ps
`default_nettype none
module twb_assertions (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic scl,
    input wire logic sda,
    input wire logic m_scl_out,
    input wire logic m_scl_oe_n,
    input wire logic m_sda_out,
    input wire logic m_sda_oe_n,
    input wire logic s_scl_out,
    input wire logic s_scl_oe_n,
    input wire logic s_sda_out,
    input wire logic s_sda_oe_n
);
    logic scl_q; // previous clock level
    logic sda_q; // previous data level
    logic busy; // frame open
    logic [7:0] rises; // clock rises since last start or stop
    wire start = scl && scl_q && sda_q && !sda; // data falls, clock high
    wire stop = scl && scl_q && !sda_q && sda; // data rises, clock high
    // short frames only, so the count never wraps
    always_ff @(posedge sys_clk_in) begin
        scl_q <= scl;
        sda_q <= sda;
        busy <= !rst_in && (start || (busy && !stop));
        rises <= (rst_in || start || stop) ? 8'h00 : rises + {7'h00, scl && !scl_q};
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    a_pull_low_only: assert property (!(m_scl_out | m_sda_out | s_scl_out | s_sda_out))
        else $error("wire driven high");
    a_frame_nine_bits: assert property ((start || stop) && busy |-> rises % 9 == 1)
        else $error("segment not nine clocks");
    a_slave_data_low: assert property ($changed(s_sda_oe_n) |-> !scl && !$past(scl))
        else $error("slave data moved with clock high");
    a_stretch_on_low: assert property ($fell(s_scl_oe_n) |-> !$past(scl))
        else $error("slave pulled a high clock");
    a_scl_high_min: assert property ($rose(scl) |=> scl [*8])
        else $error("clock high too short");
    a_scl_low_min: assert property ($fell(scl) |=> !scl [*8])
        else $error("clock low too short");
    a_idle_all_quiet: assert property (!busy |-> s_sda_oe_n && s_scl_oe_n && m_scl_oe_n)
        else $error("wire held while idle");
    a_ack_sender_free: assert property (scl && !scl_q && busy && rises % 9 == 8 |-> m_sda_oe_n || s_sda_oe_n)
        else $error("both ends hold data in ack slot");
    c_restart: cover property (start && busy);
    c_stop: cover property (stop);
    c_stretch: cover property (!s_scl_oe_n);
endmodule : twb_assertions
`default_nettype wire

// >>> tb/two_wire_bus_protocol_engine_tb.sv
// Purpose: end-to-end write, read and restart runs across both ends
// Assumes: slave own address 7'h2A
// Notes: reset held four cycles so the link domain sees it too
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_protocol_engine_tb;
    import twb_pkg::*;
    logic sys_clk_in = 1'b0;
    logic link_clk_in = 1'b0; // slave bus-side clock
    logic rst_in = 1'b1;
    logic cmd_valid_in = 1'b0;
    cmd_t cmd_in = CMD_STOP;
    logic [7:0] data_in = 8'h00;
    logic ack_in = 1'b0;
    logic tx_load_in = 1'b0;
    logic [7:0] tx_data_in = 8'h00;
    logic cmd_ready_out, done_out, nack_out, m_busy, s_busy, rx_valid_out, tx_rdy;
    logic [7:0] rd_data_out, rx_data_out;
    logic [7:0] rx_last = 8'h00; // last byte the slave handed up
    int err_count = 0;
    int n_tests = 0;
    always #12.5 sys_clk_in = ~sys_clk_in;
    always #7.5 link_clk_in = ~link_clk_in;
    twb_bus_if bus_if ();
    twb_master u_twb_master (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
        .cmd_in(cmd_in), .data_in(data_in), .ack_in(ack_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out),
        .rd_data_out(rd_data_out), .nack_out(nack_out), .arb_lost_out(), .bus_busy_out(m_busy), .bus(bus_if));
    twb_slave u_twb_slave (.sys_clk_in(sys_clk_in), .link_clk_in(link_clk_in), .rst_in(rst_in),
        .tx_load_in(tx_load_in), .tx_data_in(tx_data_in), .tx_ready_out(tx_rdy), .rx_valid_out(rx_valid_out),
        .rx_data_out(rx_data_out), .bus_busy_out(s_busy), .bus(bus_if));
    twb_assertions u_twb_assertions (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl(bus_if.scl),
        .sda(bus_if.sda), .m_scl_out(bus_if.m_scl_out), .m_scl_oe_n(bus_if.m_scl_oe_n),
        .m_sda_out(bus_if.m_sda_out), .m_sda_oe_n(bus_if.m_sda_oe_n), .s_scl_out(bus_if.s_scl_out),
        .s_scl_oe_n(bus_if.s_scl_oe_n),
        .s_sda_out(bus_if.s_sda_out), .s_sda_oe_n(bus_if.s_sda_oe_n));
    // keep the pulse's byte, since it stands one cycle only
    always @(posedge sys_clk_in) if (rx_valid_out === 1'b1) rx_last <= rx_data_out;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one command, offered when ready, finished at done
    task automatic send(input cmd_t c, input logic [7:0] d, input logic a);
        int i;
        for (i = 0; i < 9000 && cmd_ready_out !== 1'b1; i++) @(posedge sys_clk_in);
        cmd_valid_in <= 1'b1;
        cmd_in <= c;
        data_in <= d;
        ack_in <= a;
        @(posedge sys_clk_in);
        cmd_valid_in <= 1'b0;
        for (i = 0; i < 9000 && done_out !== 1'b1; i++) @(posedge sys_clk_in);
        chk({7'h00, done_out}, 8'h01);
    endtask : send
    task automatic load(input logic [7:0] d);
        tx_data_in <= d;
        tx_load_in <= 1'b1;
        @(posedge sys_clk_in);
        tx_load_in <= 1'b0;
    endtask : load
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        load(8'hC3);
        send(CMD_START, 8'h54, 1'b0);
        chk({7'h00, nack_out}, 8'h00);
        send(CMD_WRITE, 8'hA5, 1'b0);
        chk({7'h00, nack_out}, 8'h00);
        chk(rx_last, 8'hA5);
        send(CMD_START, 8'h54, 1'b0);
        send(CMD_WRITE, 8'h3C, 1'b0);
        chk(rx_last, 8'h3C);
        send(CMD_START, 8'h55, 1'b0);
        send(CMD_READ, 8'h00, 1'b1);
        chk(rd_data_out, 8'hC3);
        load(8'h96);
        send(CMD_READ, 8'h00, 1'b0);
        chk(rd_data_out, 8'h96);
        send(CMD_STOP, 8'h00, 1'b0);
        repeat (20) @(posedge sys_clk_in);
        chk({6'h00, m_busy, s_busy}, 8'h00);
        chk({7'h00, tx_rdy}, 8'h01);
        send(CMD_START, 8'h56, 1'b0);
        chk({7'h00, nack_out}, 8'h01);
        send(CMD_STOP, 8'h00, 1'b0);
        print_verdict();
    end
    initial begin
        #2000000;
        err_count++;
        print_verdict();
    end
endmodule : two_wire_bus_protocol_engine_tb
`default_nettype wire
